// ### rtl/scpm_pkg.sv
// scpm_pkg: constants and types of the smart card function power-management config registers
// assumes: one clock domain (mclk), configuration accesses addressed by dword index
package scpm_pkg;

  // dword indices of configuration space (byte offset / 4)
  localparam logic [5:0]  SCPM_DW_SUBSYS_HDR   = 6'h0B;   // 2Ch/2Eh header alias
  localparam logic [5:0]  SCPM_DW_CAP_HDR      = 6'h11;   // 44h/46h
  localparam logic [5:0]  SCPM_DW_PM_CSR       = 6'h12;   // 48h/4Ah/4Bh
  localparam logic [5:0]  SCPM_DW_GEN_CTL      = 6'h13;   // 4Ch
  localparam logic [5:0]  SCPM_DW_SUBSYS_ALIAS = 6'h14;   // 50h

  // byte offsets as printed
  localparam logic [7:0]  SCPM_OFS_PM_CSR      = 8'h48;
  localparam logic [7:0]  SCPM_OFS_BRIDGE_EXT  = 8'h4A;
  localparam logic [7:0]  SCPM_OFS_DATA_BYTE   = 8'h4B;
  localparam logic [7:0]  SCPM_OFS_GEN_CTL     = 8'h4C;
  localparam logic [7:0]  SCPM_OFS_SUBSYS      = 8'h50;

  // power management control/status fields
  localparam int          SCPM_PMCSR_STAT_BIT  = 15;
  localparam int          SCPM_PMCSR_EN_BIT    = 8;
  localparam int          SCPM_PMCSR_STATE_LSB = 0;

  // general control fields
  localparam int          SCPM_GC_INTSEL_LSB   = 5;
  localparam int          SCPM_GC_COLD_BIT     = 4;

  // reset and fixed values
  localparam logic [15:0] SCPM_PMCSR_RST       = 16'h0000;
  localparam logic [7:0]  SCPM_BRIDGE_EXT_VAL  = 8'h00;
  localparam logic [7:0]  SCPM_DATA_BYTE_VAL   = 8'h00;
  localparam logic [7:0]  SCPM_GC_RST          = 8'h00;
  localparam logic [31:0] SCPM_SUBSYS_RST      = 32'h0000_0000;
  localparam logic [15:0] SCPM_CAP_ID_NEXT     = 16'h0001;
  localparam logic [3:0]  SCPM_WAKE_STATES     = 4'hF;
  localparam logic [2:0]  SCPM_AUX_SELF        = 3'h0;
  localparam logic [2:0]  SCPM_AUX_55MA        = 3'h1;
  localparam logic [2:0]  SCPM_PM_VERSION      = 3'h2;
  localparam logic [31:0] SCPM_UNMAPPED_DATA   = 32'h0000_0000;

  // strap synchroniser depth
  localparam int          SCPM_SYNC_STAGES     = 2;

  typedef enum logic [1:0] {
    SCPM_D0    = 2'h0,
    SCPM_D1    = 2'h1,
    SCPM_D2    = 2'h2,
    SCPM_D3HOT = 2'h3
  } scpm_pstate_t;

  typedef enum logic [1:0] {
    SCPM_INTA = 2'h0,
    SCPM_INTB = 2'h1,
    SCPM_INTC = 2'h2,
    SCPM_INTD = 2'h3
  } scpm_int_line_t;

  // one configuration request, taken in the cycle req is high
  typedef struct packed {
    logic        req;
    logic        we;
    logic [5:0]  dw;
    logic [3:0]  be;
    logic [31:0] wdata;
  } scpm_cfg_req_t;

  // configuration answer
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } scpm_cfg_rsp_t;

endpackage

// ### rtl/scpm_sync.sv
// scpm_sync: multi-bit two-flop level synchroniser for pin inputs
// assumes: each bit is an independent level, mclk domain on the output side
`timescale 1ns/1ps
`default_nettype none

module scpm_sync
  import scpm_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // -----------------------------------------------------------------
  // two stages; first stage feeds only the second
  // -----------------------------------------------------------------
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stable_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r   <= '0;
      stable_r <= '0;
    end else begin
      meta_r   <= async_in;
      stable_r <= meta_r;
    end
  end

  assign sync_out = stable_r;

endmodule

`default_nettype wire

// ### rtl/scpm_pm_regs.sv
// scpm_pm_regs: power-management and general control config registers of the smart card function
// assumes: rst_n is the global reset pin; config requests and wake/irq inputs are mclk-synchronous;
// interrupt-routing straps come from pins and are synchronised here
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - The control/status register keeps its contents across the internal reset made when leaving D3hot for D0.
// - Bit 15 of the control/status register is a wake status flag that resets to zero, is set by hardware and cleared by software.
// - The data-scale field (bits 14-13) and the data-select field (bits 12-9) always read zero.
// - Bit 8 is a read/write wake enable, and the wake output is asserted only if it was set in the previous cycle.
// - Bits 7-2 of the control/status register read zero and ignore writes.
// - Bits 1-0 report the current power state as 00 D0, 01 D1, 10 D2, 11 D3hot.
// - A host write of an encoding to the power state field moves the function to that state, which later reads report.
// - Wake status, wake enable, power state, interrupt select and cold-off wake support clear only on the global reset pin.
// - The bridge extension byte at 4Ah and the data byte at 4Bh are read-only and always read zero.
// - Interrupt select in bits 6-5 chooses INTA to INTD as 00 to 11, and the interrupt pin value follows it.
// - If any interrupt-routing strap is asserted the select field is ignored and the strap picks the line.
// - The cold-off wake support bit 4 of general control is mirrored into the capabilities register's wake capable bit.
// - General control bit 7 and bits 3-0 read zero, and the register resets to zero.
// - Bits 31-16 of the subsystem alias register appear as the subsystem device ID at offset 2Eh.
// - Bits 15-0 of the subsystem alias register appear as the subsystem vendor ID at offset 2Ch.
// - The auxiliary current field reads 000 while cold-off wake support is clear and 001 while it is set.
module scpm_pm_regs
  import scpm_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire scpm_cfg_req_t cfg_req,
  output scpm_cfg_rsp_t      cfg_rsp,
  input  wire logic          wake_event_in,
  input  wire logic          func_irq,
  input  wire logic [3:0]    interrupt_route_straps,
  output logic               wake_pin_out,
  output logic               wake_pin_oe,
  output logic [3:0]         int_pin_out,
  output logic [3:0]         int_pin_oe,
  output logic [7:0]         int_pin_value,
  output logic [1:0]         power_state_field,
  output logic               func_reset,
  output logic [15:0]        subsys_vendor_ident,
  output logic [15:0]        subsys_device_ident,
  output logic               cold_off_wake_capable
);

  // -----------------------------------------------------------------
  // storage
  // -----------------------------------------------------------------
  logic                 wake_event_status_r;
  logic                 wake_event_enable_r;
  scpm_pstate_t         power_state_r;
  logic [1:0]           int_sel_r;
  logic                 cold_off_wake_support_ctl_r;
  logic [31:0]          subsys_alias_r;
  logic                 func_reset_r;
  scpm_cfg_rsp_t        rsp_r;
  logic                 wake_oe_r;
  logic [3:0]           int_oe_r;
  logic [3:0]           straps_s;

  // -----------------------------------------------------------------
  // access decode
  // -----------------------------------------------------------------
  logic                 wr_pmcsr;
  logic                 wr_gc;
  logic                 wr_alias;
  logic                 clr_status;
  logic                 leave_d3hot;
  logic [15:0]          pmcsr_view;
  logic [15:0]          caps_view;
  logic [7:0]           gc_view;
  logic [2:0]           aux_current;
  scpm_int_line_t       route;
  logic [31:0]          rdata_nxt;

  assign wr_pmcsr    = cfg_req.req && cfg_req.we && (cfg_req.dw == SCPM_DW_PM_CSR);
  assign wr_gc       = cfg_req.req && cfg_req.we && (cfg_req.dw == SCPM_DW_GEN_CTL);
  assign wr_alias    = cfg_req.req && cfg_req.we && (cfg_req.dw == SCPM_DW_SUBSYS_ALIAS);

  // write one to bit 15 clears wake status
  assign clr_status  = wr_pmcsr && cfg_req.be[1] && cfg_req.wdata[SCPM_PMCSR_STAT_BIT];

  // D3hot to D0 transition triggers the function's internal reset
  assign leave_d3hot = wr_pmcsr && cfg_req.be[0] && (power_state_r == SCPM_D3HOT)
                       && (cfg_req.wdata[SCPM_PMCSR_STATE_LSB +: 2] == SCPM_D0);

  // -----------------------------------------------------------------
  // strap synchroniser
  // -----------------------------------------------------------------
  scpm_sync #(
    .WIDTH (4)
  ) u_strap_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (interrupt_route_straps),
    .sync_out (straps_s)
  );

  // -----------------------------------------------------------------
  // wake status and enable
  // -----------------------------------------------------------------
  // only the global reset pin clears these; the internal reset does not
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_event_status_r <= SCPM_PMCSR_RST[SCPM_PMCSR_STAT_BIT];
    end else if (wake_event_in) begin
      wake_event_status_r <= 1'b1;
    end else if (clr_status) begin
      wake_event_status_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_event_enable_r <= SCPM_PMCSR_RST[SCPM_PMCSR_EN_BIT];
    end else if (wr_pmcsr && cfg_req.be[1]) begin
      wake_event_enable_r <= cfg_req.wdata[SCPM_PMCSR_EN_BIT];
    end
  end

  // -----------------------------------------------------------------
  // power state
  // -----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      power_state_r <= SCPM_D0;
    end else if (wr_pmcsr && cfg_req.be[0]) begin
      power_state_r <= scpm_pstate_t'(cfg_req.wdata[SCPM_PMCSR_STATE_LSB +: 2]);
    end
  end

  // one-cycle internal reset pulse on leaving D3hot
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      func_reset_r <= 1'b0;
    end else begin
      func_reset_r <= leave_d3hot;
    end
  end

  // -----------------------------------------------------------------
  // general control
  // -----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_sel_r <= SCPM_GC_RST[SCPM_GC_INTSEL_LSB +: 2];
    end else if (wr_gc && cfg_req.be[0]) begin
      int_sel_r <= cfg_req.wdata[SCPM_GC_INTSEL_LSB +: 2];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cold_off_wake_support_ctl_r <= SCPM_GC_RST[SCPM_GC_COLD_BIT];
    end else if (wr_gc && cfg_req.be[0]) begin
      cold_off_wake_support_ctl_r <= cfg_req.wdata[SCPM_GC_COLD_BIT];
    end
  end

  // -----------------------------------------------------------------
  // subsystem alias
  // -----------------------------------------------------------------
  // not sticky: the internal reset returns it to its default
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      subsys_alias_r <= SCPM_SUBSYS_RST;
    end else if (func_reset_r) begin
      subsys_alias_r <= SCPM_SUBSYS_RST;
    end else if (wr_alias) begin
      for (int b = 0; b < 4; b++) begin
        if (cfg_req.be[b]) begin
          subsys_alias_r[8*b +: 8] <= cfg_req.wdata[8*b +: 8];
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // register views
  // -----------------------------------------------------------------
  // internal reset touches none of these fields
  always_comb begin
    pmcsr_view                             = SCPM_PMCSR_RST;
    pmcsr_view[SCPM_PMCSR_STAT_BIT]        = wake_event_status_r;
    pmcsr_view[SCPM_PMCSR_EN_BIT]          = wake_event_enable_r;
    pmcsr_view[SCPM_PMCSR_STATE_LSB +: 2]  = power_state_r;
  end

  assign aux_current = cold_off_wake_support_ctl_r ? SCPM_AUX_55MA : SCPM_AUX_SELF;

  always_comb begin
    caps_view = {cold_off_wake_support_ctl_r, SCPM_WAKE_STATES, 1'b1, 1'b1, aux_current,
                 3'h0, SCPM_PM_VERSION};
  end

  always_comb begin
    gc_view                               = SCPM_GC_RST;
    gc_view[SCPM_GC_INTSEL_LSB +: 2]      = int_sel_r;
    gc_view[SCPM_GC_COLD_BIT]             = cold_off_wake_support_ctl_r;
  end

  // -----------------------------------------------------------------
  // read mux
  // -----------------------------------------------------------------
  always_comb begin
    case (cfg_req.dw)
      SCPM_DW_SUBSYS_HDR: begin
        rdata_nxt = subsys_alias_r;
      end
      SCPM_DW_CAP_HDR: begin
        rdata_nxt = {caps_view, SCPM_CAP_ID_NEXT};
      end
      SCPM_DW_PM_CSR: begin
        rdata_nxt = {SCPM_DATA_BYTE_VAL, SCPM_BRIDGE_EXT_VAL, pmcsr_view};
      end
      SCPM_DW_GEN_CTL: begin
        rdata_nxt = {24'h00_0000, gc_view};
      end
      SCPM_DW_SUBSYS_ALIAS: begin
        rdata_nxt = subsys_alias_r;
      end
      default: begin
        rdata_nxt = SCPM_UNMAPPED_DATA;
      end
    endcase
  end

  // one-cycle answer to every request; read data only on reads
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_r <= '0;
    end else begin
      rsp_r.ack <= cfg_req.req;
      if (cfg_req.req && !cfg_req.we) begin
        rsp_r.rdata <= rdata_nxt;
      end
    end
  end

  // -----------------------------------------------------------------
  // interrupt routing
  // -----------------------------------------------------------------
  // lowest asserted strap wins over the select field
  always_comb begin
    route = scpm_int_line_t'(int_sel_r);
    for (int i = 3; i >= 0; i--) begin
      if (straps_s[i]) begin
        route = scpm_int_line_t'(i[1:0]);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_oe_r <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        int_oe_r[i] <= func_irq && (route == scpm_int_line_t'(i[1:0]));
      end
    end
  end

  // -----------------------------------------------------------------
  // wake output
  // -----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_oe_r <= 1'b0;
    end else begin
      wake_oe_r <= wake_event_status_r && wake_event_enable_r && !clr_status;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign cfg_rsp               = rsp_r;
  assign wake_pin_out          = 1'b0;
  assign wake_pin_oe           = wake_oe_r;
  assign int_pin_out           = 4'h0;
  assign int_pin_oe            = int_oe_r;
  assign int_pin_value         = {6'h00, route} + 8'h01;
  assign power_state_field     = power_state_r;
  assign func_reset            = func_reset_r;
  assign subsys_vendor_ident   = subsys_alias_r[15:0];
  assign subsys_device_ident   = subsys_alias_r[31:16];
  assign cold_off_wake_capable = cold_off_wake_support_ctl_r;

endmodule

`default_nettype wire

// ### bench/scpm_pm_regs_sva.sv
// scpm_pm_regs_sva: port-level checks of the power-management config registers
// assumes: bound to scpm_pm_regs, one clock mclk, rst_n as global reset
`timescale 1ns/1ps
`default_nettype none
module scpm_pm_regs_sva
  import scpm_pkg::*;
(
  input wire logic          mclk,
  input wire logic          rst_n,
  input wire scpm_cfg_req_t cfg_req,
  input wire scpm_cfg_rsp_t cfg_rsp,
  input wire logic          func_irq,
  input wire logic [3:0]    int_pin_oe,
  input wire logic [7:0]    int_pin_value,
  input wire logic [1:0]    power_state_field,
  input wire logic          func_reset,
  input wire logic [15:0]   subsys_vendor_ident,
  input wire logic [15:0]   subsys_device_ident,
  input wire logic          cold_off_wake_capable,
  input wire logic          wake_pin_oe
);
  // ----------------------------------------
  // decoded accesses
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic wr, rd;
  assign wr = cfg_req.req && cfg_req.we;
  assign rd = cfg_req.req && !cfg_req.we;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  ack_follow_a: assert property (cfg_req.req |=> cfg_rsp.ack)
    else $error("no answer one cycle after request");
  state_write_a: assert property (wr && cfg_req.dw == SCPM_DW_PM_CSR && cfg_req.be[0]
    |=> power_state_field == $past(cfg_req.wdata[1:0])) else $error("power state not taken");
  state_read_a: assert property (rd && cfg_req.dw == SCPM_DW_PM_CSR
    |=> cfg_rsp.rdata[1:0] == $past(power_state_field)) else $error("power state read wrong");
  pmcsr_zero_a: assert property (rd && cfg_req.dw == SCPM_DW_PM_CSR
    |=> cfg_rsp.rdata[31:16] == 16'h0000 && cfg_rsp.rdata[14:9] == 6'h00 && cfg_rsp.rdata[7:2] == 6'h00)
    else $error("fixed bits not zero");
  genctl_zero_a: assert property (rd && cfg_req.dw == SCPM_DW_GEN_CTL
    |=> cfg_rsp.rdata[7] == 1'b0 && cfg_rsp.rdata[3:0] == 4'h0) else $error("control spare bits not zero");
  cold_mirror_a: assert property (wr && cfg_req.dw == SCPM_DW_GEN_CTL && cfg_req.be[0]
    |=> cold_off_wake_capable == $past(cfg_req.wdata[4])) else $error("wake capable not mirrored");
  aux_current_a: assert property (rd && cfg_req.dw == SCPM_DW_CAP_HDR
    |=> cfg_rsp.rdata[31:22] == {$past(cold_off_wake_capable), 6'h3F, 2'h0, $past(cold_off_wake_capable)})
    else $error("capabilities read wrong");
  alias_write_a: assert property (wr && cfg_req.dw == SCPM_DW_SUBSYS_ALIAS && cfg_req.be == 4'hF
    |=> {subsys_device_ident, subsys_vendor_ident} == $past(cfg_req.wdata)) else $error("alias not shown");
  int_route_a: assert property (int_pin_oe ==
    ($past(func_irq) ? 4'h1 << ($past(int_pin_value[1:0]) - 2'h1) : 4'h0)) else $error("interrupt line wrong");
  keep_on_reset_a: assert property (func_reset
    |=> $stable(power_state_field) && $stable(cold_off_wake_capable)) else $error("state lost on internal reset");
  cover property (wr && cfg_req.dw == SCPM_DW_PM_CSR && cfg_req.wdata[1:0] == 2'h3);
  cover property (func_reset);
  cover property ($rose(wake_pin_oe));
endmodule
`default_nettype wire

// ### bench/scpm_host.sv
// scpm_host: configuration host issuing single accesses to the register block
// assumes: request driven at falling edge, answer read at the next falling edge, half a cycle after the taking edge
`timescale 1ns/1ps
`default_nettype none
module scpm_host
  import scpm_pkg::*;
(
  input  wire logic          mclk,
  output scpm_cfg_req_t      cfg_req,
  input  wire scpm_cfg_rsp_t cfg_rsp
);
  // ----------------------------------------
  // one access
  // ----------------------------------------
  initial cfg_req = '0;
  task automatic xfer(input logic we, input logic [5:0] dw, input logic [3:0] be,
                      input logic [31:0] wd, output logic [31:0] rdata, output logic ok);
    @(negedge mclk);
    cfg_req = '{req: 1'b1, we: we, dw: dw, be: be, wdata: wd};
    @(negedge mclk);
    // released lines show the inverse, never the last value
    cfg_req = '{req: 1'b0, we: ~we, dw: ~dw, be: ~be, wdata: ~wd};
    ok = (cfg_rsp.ack === 1'b1);
    rdata = cfg_rsp.rdata;
  endtask
endmodule
`default_nettype wire

// ### bench/test_scpm_pm_regs.sv
// test_scpm_pm_regs: self-checking bench of the power-management config registers
// assumes: scpm_host model drives the config port, bench drives pins at falling edge
`timescale 1ns/1ps
`default_nettype none
module test_scpm_pm_regs
  import scpm_pkg::*;
;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic          mclk, rst_n, wake_event_in, func_irq, ok;
  logic [3:0]    interrupt_route_straps, int_pin_out, int_pin_oe;
  scpm_cfg_req_t cfg_req;
  scpm_cfg_rsp_t cfg_rsp;
  logic          wake_pin_out, wake_pin_oe, func_reset, cold_off_wake_capable;
  logic [7:0]    int_pin_value;
  logic [1:0]    power_state_field;
  logic [15:0]   subsys_vendor_ident, subsys_device_ident;
  logic [31:0]   rd;
  int            num_errors = 0;
  int            comparisons = 0;
  int            cycles = 0;
  scpm_host u_host(.mclk(mclk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));
  scpm_pm_regs u_dut(.mclk(mclk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
    .wake_event_in(wake_event_in), .func_irq(func_irq), .interrupt_route_straps(interrupt_route_straps),
    .wake_pin_out(wake_pin_out), .wake_pin_oe(wake_pin_oe), .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe),
    .int_pin_value(int_pin_value), .power_state_field(power_state_field), .func_reset(func_reset),
    .subsys_vendor_ident(subsys_vendor_ident), .subsys_device_ident(subsys_device_ident),
    .cold_off_wake_capable(cold_off_wake_capable));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic give_verdict;
    if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic acc(input logic we, input logic [5:0] dw, input logic [3:0] be, input logic [31:0] wd);
    u_host.xfer(we, dw, be, wd, rd, ok);
    chk("ack", 32'h1, {31'h0, ok});
  endtask
  task automatic rdc(input string nm, input logic [5:0] dw, input logic [31:0] exp);
    acc(1'b0, dw, 4'hF, 32'h0);
    chk(nm, exp, rd);
  endtask
  task automatic pulse_wake;
    @(negedge mclk) wake_event_in = 1'b1;
    @(negedge mclk) wake_event_in = 1'b0;
    @(negedge mclk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_values;
    rdc("pmcsr", SCPM_DW_PM_CSR, 32'h0000_0000);
    rdc("genctl", SCPM_DW_GEN_CTL, 32'h0000_0000);
    rdc("alias", SCPM_DW_SUBSYS_ALIAS, 32'h0000_0000);
    rdc("caps", SCPM_DW_CAP_HDR, 32'h7E02_0001);
  endtask
  task automatic t_power_states;
    for (int s = 0; s < 4; s++) begin
      acc(1'b1, SCPM_DW_PM_CSR, 4'hD, 32'hFFFF_FEFC | 32'(s));
      chk("state", 32'(s), {30'h0, power_state_field});
      rdc("pmcsr", SCPM_DW_PM_CSR, 32'(s));
    end
  endtask
  task automatic t_wake;
    acc(1'b1, SCPM_DW_PM_CSR, 4'h2, 32'h0000_0100);
    pulse_wake;
    chk("wake_oe", 32'h1, {31'h0, wake_pin_oe});
    rdc("pmcsr", SCPM_DW_PM_CSR, 32'h0000_8103);
    acc(1'b1, SCPM_DW_PM_CSR, 4'h2, 32'h0000_8100);
    chk("wake_oe", 32'h0, {31'h0, wake_pin_oe});
    rdc("pmcsr", SCPM_DW_PM_CSR, 32'h0000_0103);
    acc(1'b1, SCPM_DW_PM_CSR, 4'h2, 32'h0000_0000);
    pulse_wake;
    chk("wake_oe", 32'h0, {31'h0, wake_pin_oe});
    rdc("pmcsr", SCPM_DW_PM_CSR, 32'h0000_8003);
    acc(1'b1, SCPM_DW_PM_CSR, 4'h2, 32'h0000_8000);
    rdc("pmcsr", SCPM_DW_PM_CSR, 32'h0000_0003);
  endtask
  task automatic t_genctl;
    acc(1'b1, SCPM_DW_GEN_CTL, 4'h1, 32'hFFFF_FFFF);
    rdc("genctl", SCPM_DW_GEN_CTL, 32'h0000_0070);
    chk("cold_cap", 32'h1, {31'h0, cold_off_wake_capable});
    rdc("caps", SCPM_DW_CAP_HDR, 32'hFE42_0001);
    func_irq = 1'b1;
    for (int s = 0; s < 4; s++) begin
      acc(1'b1, SCPM_DW_GEN_CTL, 4'h1, 32'(s << 5));
      chk("pin_value", 32'(s + 1), {24'h0, int_pin_value});
      @(negedge mclk);
      chk("int_oe", 32'(1 << s), {28'h0, int_pin_oe});
    end
    chk("cold_cap", 32'h0, {31'h0, cold_off_wake_capable});
    rdc("caps", SCPM_DW_CAP_HDR, 32'h7E02_0001);
    chk("int_out", 32'h0, {28'h0, int_pin_out});
    chk("wake_out", 32'h0, {31'h0, wake_pin_out});
    interrupt_route_straps = 4'h6;
    repeat (3) @(negedge mclk);
    chk("pin_value", 32'h2, {24'h0, int_pin_value});
    chk("int_oe", 32'h2, {28'h0, int_pin_oe});
    interrupt_route_straps = 4'h0;
    func_irq = 1'b0;
    repeat (3) @(negedge mclk);
    chk("int_oe", 32'h0, {28'h0, int_pin_oe});
  endtask
  task automatic t_alias;
    acc(1'b1, SCPM_DW_SUBSYS_ALIAS, 4'hF, 32'hA5C3_5A3C);
    chk("ids", 32'hA5C3_5A3C, {subsys_device_ident, subsys_vendor_ident});
    rdc("hdr", SCPM_DW_SUBSYS_HDR, 32'hA5C3_5A3C);
    acc(1'b1, SCPM_DW_SUBSYS_ALIAS, 4'h3, 32'h1111_2222);
    chk("ids", 32'hA5C3_2222, {subsys_device_ident, subsys_vendor_ident});
  endtask
  task automatic t_d3_exit;
    acc(1'b1, SCPM_DW_GEN_CTL, 4'h1, 32'h0000_0010);
    acc(1'b1, SCPM_DW_PM_CSR, 4'h2, 32'h0000_0100);
    acc(1'b1, SCPM_DW_PM_CSR, 4'h1, 32'h0000_0000);
    chk("func_reset", 32'h1, {31'h0, func_reset});
    rdc("pmcsr", SCPM_DW_PM_CSR, 32'h0000_0100);
    rdc("genctl", SCPM_DW_GEN_CTL, 32'h0000_0010);
    rdc("alias", SCPM_DW_SUBSYS_ALIAS, 32'h0000_0000);
    @(negedge mclk) rst_n = 1'b0;
    @(negedge mclk) rst_n = 1'b1;
    rdc("pmcsr", SCPM_DW_PM_CSR, 32'h0000_0000);
    rdc("genctl", SCPM_DW_GEN_CTL, 32'h0000_0000);
  endtask
  // ----------------------------------------
  // clock, sequence, timeout
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    rst_n = 1'b0;
    wake_event_in = 1'b0;
    func_irq = 1'b0;
    interrupt_route_straps = 4'h0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    t_reset_values;
    t_power_states;
    t_wake;
    t_genctl;
    t_alias;
    t_d3_exit;
    give_verdict;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      give_verdict;
    end
  end
endmodule
bind scpm_pm_regs scpm_pm_regs_sva u_sva(.mclk, .rst_n, .cfg_req, .cfg_rsp, .func_irq, .int_pin_oe,
  .int_pin_value, .power_state_field, .func_reset, .subsys_vendor_ident, .subsys_device_ident,
  .cold_off_wake_capable, .wake_pin_oe);
`default_nettype wire
